//--- rtl/cfd_flags.sv
// Package of constants and the arithmetic flag calculator.
// Operation
// - add, add with carry, borrow subtract update carry, signed wrap, nibble.
// - byte writes to the status word at 208, or bit writes at 208-215, change flags.
// - interrupt: finish, push program counter, vector within 38 to 81 periods.
// - bank register operand picks one of eight in current bank.
// - direct address 0-127 is RAM, 128-255 is special register space.
// - indirect operand reaches RAM 0-255 through pointer register 0 or 1.
// - decimal adjust, rotates through carry, bit ops, compare-jump change carry.
// - relative branch adds signed byte to next instruction address.
// - 11-bit target replaces low bits within the same 2K page.
package cfd_pkg;
  localparam logic [7:0] STAT_ADDR     = 8'hd0;
  localparam logic [7:0] STAT_BIT_BASE = 8'hd0;
  localparam logic [7:0] SPEC_BASE     = 8'h80;
  localparam logic [7:0] STAT_RST      = 8'h00;
  localparam int         C_POS         = 7;
  localparam int         NIB_POS       = 6;
  localparam int         RS_LO         = 3;
  localparam int         WRAP_POS      = 2;
  localparam int         OSC_PERIOD_NS = 10;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         LAT_MIN_OSC  = 38;
  localparam int         LAT_MAX_OSC  = 81;
  localparam int         LAT_MIN_CYC  =
    (LAT_MIN_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         LAT_MAX_CYC  =
    (LAT_MAX_OSC * OSC_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int         PUSH_CYC     = 2;
  localparam logic [7:0] LAT_CNT_RST  = 8'h00;
  localparam logic [15:0] PC_RST      = 16'h0000;

  typedef enum logic [4:0] {
    OP_NOP  = 5'h00, OP_ADD  = 5'h01, OP_ADCY = 5'h02, OP_SBBR = 5'h03,
    OP_PROD = 5'h04, OP_QUOT = 5'h05, OP_BCDA = 5'h06, OP_RORC = 5'h07,
    OP_ROLC = 5'h08, OP_SETC = 5'h09, OP_CLRC = 5'h0a, OP_CPLC = 5'h0b,
    OP_ANLC = 5'h0c, OP_ORLC = 5'h0d, OP_ANLN = 5'h0e, OP_ORLN = 5'h0f,
    OP_MOVC = 5'h10, OP_CMPJ = 5'h11, OP_LOGIC = 5'h12
  } cfd_op_t;

  typedef enum logic [1:0] {
    MODE_BANK = 2'b00, MODE_DIRECT = 2'b01, MODE_INDIRECT = 2'b10
  } cfd_mode_t;

  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00, IRQ_WAIT = 2'b01, IRQ_PUSH = 2'b10, IRQ_VEC = 2'b11
  } cfd_irq_t;
endpackage : cfd_pkg

`timescale 1ns/10ps
`default_nettype none
module cfd_flags (
  input  wire logic         [4:0] op_i,   // Instruction class.
  input  wire logic         [7:0] a_i,    // Accumulator operand.
  input  wire logic         [7:0] b_i,    // Second operand.
  input  wire logic               c_i,    // Current carry.
  input  wire logic               nib_i,  // Current nibble carry.
  input  wire logic               bit_i,  // Addressed bit value.
  output logic              [7:0] lo_o,   // Result low byte.
  output logic              [7:0] hi_o,   // Result high byte.
  output logic                    c_o,    // New carry.
  output logic                    wrap_o, // New signed wrap.
  output logic                    nib_o,  // New nibble carry.
  output logic              [2:0] upd_o   // Update mask {c, ov, ac}.
);
  logic [8:0]  s9;
  logic [4:0]  n5;
  logic [15:0] p16;
  logic [8:0]  da9;
  logic        cin;

  always_comb begin
    cin  = (op_i == cfd_pkg::OP_ADD) ? 1'b0 : c_i;
    lo_o = a_i;
    hi_o = b_i;
    c_o  = c_i;
    wrap_o = 1'b0;
    nib_o  = nib_i;
    upd_o = 3'b000;
    s9  = 9'h000;
    n5  = 5'h00;
    p16 = 16'h0000;
    da9 = {1'b0, a_i};
    case (op_i)
      cfd_pkg::OP_ADD, cfd_pkg::OP_ADCY: begin
        s9   = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
        n5   = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
        lo_o = s9[7:0];
        c_o  = s9[8];
        nib_o  = n5[4];
        wrap_o = (a_i[7] == b_i[7]) && (s9[7] != a_i[7]);
        upd_o = 3'b111;
      end
      cfd_pkg::OP_SBBR: begin
        s9   = {1'b0, a_i} - {1'b0, b_i} - {8'h00, c_i};
        n5   = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, c_i};
        lo_o = s9[7:0];
        c_o  = s9[8];
        nib_o  = n5[4];
        wrap_o = (a_i[7] != b_i[7]) && (s9[7] != a_i[7]);
        upd_o = 3'b111;
      end
      cfd_pkg::OP_PROD: begin
        p16  = {8'h00, a_i} * {8'h00, b_i};
        lo_o = p16[7:0];
        hi_o = p16[15:8];
        c_o  = 1'b0;
        wrap_o = (p16[15:8] != 8'h00);
        upd_o = 3'b110;
      end
      // quotient clears carry; divide by zero sets signed wrap.
      cfd_pkg::OP_QUOT: begin
        c_o  = 1'b0;
        wrap_o = (b_i == 8'h00);
        if (b_i != 8'h00) begin
          lo_o = a_i / b_i;
          hi_o = a_i % b_i;
        end
        upd_o = 3'b110;
      end
      cfd_pkg::OP_BCDA: begin
        if (nib_i || (a_i[3:0] > 4'h9)) begin
          da9 = da9 + 9'h006;
        end
        if (c_i || da9[8] || (da9[7:4] > 4'h9)) begin
          da9 = da9 + 9'h060;
        end
        lo_o = da9[7:0];
        c_o  = c_i | da9[8];
        upd_o = 3'b100;
      end
      // rotates and bit operations on carry.
      cfd_pkg::OP_RORC: begin
        lo_o = {c_i, a_i[7:1]};
        c_o  = a_i[0];
        upd_o = 3'b100;
      end
      cfd_pkg::OP_ROLC: begin
        lo_o = {a_i[6:0], c_i};
        c_o  = a_i[7];
        upd_o = 3'b100;
      end
      cfd_pkg::OP_SETC: begin c_o = 1'b1; upd_o = 3'b100; end
      cfd_pkg::OP_CLRC: begin c_o = 1'b0; upd_o = 3'b100; end
      cfd_pkg::OP_CPLC: begin c_o = ~c_i; upd_o = 3'b100; end
      cfd_pkg::OP_ANLC: begin c_o = c_i & bit_i; upd_o = 3'b100; end
      cfd_pkg::OP_ORLC: begin c_o = c_i | bit_i; upd_o = 3'b100; end
      cfd_pkg::OP_ANLN: begin c_o = c_i & ~bit_i; upd_o = 3'b100; end
      cfd_pkg::OP_ORLN: begin c_o = c_i | ~bit_i; upd_o = 3'b100; end
      cfd_pkg::OP_MOVC: begin c_o = bit_i; upd_o = 3'b100; end
      cfd_pkg::OP_CMPJ: begin c_o = (a_i < b_i); upd_o = 3'b100; end
      default: upd_o = 3'b000;
    endcase
  end
endmodule : cfd_flags
`default_nettype wire

//--- rtl/cfd_core.sv
// Flag update, status word, operand decode, branch and interrupt timing.
`timescale 1ns/10ps
`default_nettype none
module cfd_core (
  input  wire logic        clk_i,        // Core clock.
  input  wire logic        rst_n_i,      // Asynchronous reset, active low.
  input  wire logic  [7:0] reg_addr_i,   // Register byte address.
  input  wire logic  [7:0] reg_wdata_i,  // Register write data.
  input  wire logic        reg_we_i,     // Register write strobe.
  input  wire logic        reg_re_i,     // Register read strobe.
  output logic       [7:0] reg_rdata_o,  // Read data, one cycle later.
  input  wire logic  [7:0] bit_addr_i,   // Bit address for bit write.
  input  wire logic        bit_wdata_i,  // Bit write value.
  input  wire logic        bit_we_i,     // Bit write strobe.
  input  wire logic        ins_valid_i,  // Instruction issue strobe.
  input  wire logic  [4:0] ins_op_i,     // Instruction class.
  input  wire logic  [7:0] ins_a_i,      // Accumulator operand.
  input  wire logic  [7:0] ins_b_i,      // Second operand.
  input  wire logic        ins_bit_i,    // Addressed bit value.
  output logic       [7:0] res_lo_o,     // Result low byte.
  output logic       [7:0] res_hi_o,     // Result high byte.
  output logic       [7:0] stat_o,       // Status word.
  input  wire logic  [1:0] opd_mode_i,   // Operand addressing mode.
  input  wire logic  [7:0] opd_i,        // Operand field or address.
  input  wire logic  [7:0] ptr0_i,       // Pointer register zero contents.
  input  wire logic  [7:0] ptr1_i,       // Pointer register one contents.
  output logic       [7:0] opd_addr_o,   // Decoded internal address.
  output logic             opd_spec_o,   // Address is special register.
  input  wire logic [15:0] pc_next_i,    // First byte of next instruction.
  input  wire logic  [7:0] rel_i,        // Signed branch offset.
  input  wire logic [10:0] abs11_i,      // In-page branch target.
  output logic      [15:0] rel_tgt_o,    // Relative branch target.
  output logic      [15:0] abs_tgt_o,    // In-page branch target.
  input  wire logic        irq_i,        // Interrupt request pin.
  input  wire logic        ins_done_i,   // Current instruction finished.
  output logic             irq_push_o,   // Program counter push pulse.
  output logic       [7:0] push_data_o,  // Byte being pushed.
  output logic             irq_vec_o     // First service instruction pulse.
);
  logic [7:0]  stat_q;
  logic [7:0]  rdata_q;
  logic [7:0]  lo_d, hi_d;
  logic        c_d, wrap_d, nib_d;
  logic [2:0]  upd;
  logic [2:0]  irq_sync_q;
  logic        irq_lvl_q;
  logic [7:0]  lat_q;
  logic [0:0]  push_q;
  logic [15:0] pc_q;
  cfd_pkg::cfd_irq_t irq_st_q;

  cfd_flags u_flags (
    .op_i  (ins_op_i),
    .a_i   (ins_a_i),
    .b_i   (ins_b_i),
    .c_i   (stat_q[cfd_pkg::C_POS]),
    .nib_i (stat_q[cfd_pkg::NIB_POS]),
    .bit_i (ins_bit_i),
    .lo_o  (lo_d),
    .hi_o  (hi_d),
    .c_o   (c_d),
    .wrap_o(wrap_d),
    .nib_o (nib_d),
    .upd_o (upd)
  );

  // Status word: software writes first, instruction flag results win.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_q <= cfd_pkg::STAT_RST;
    end else begin
      if (reg_we_i && (reg_addr_i == cfd_pkg::STAT_ADDR)) begin
        stat_q <= reg_wdata_i;
      end else if (bit_we_i &&
                   (bit_addr_i[7:3] == cfd_pkg::STAT_BIT_BASE[7:3])) begin
        stat_q[bit_addr_i[2:0]] <= bit_wdata_i;
      end
      if (ins_valid_i) begin
        if (upd[2]) begin
          stat_q[cfd_pkg::C_POS] <= c_d;
        end
        if (upd[1]) begin
          stat_q[cfd_pkg::WRAP_POS] <= wrap_d;
        end
        if (upd[0]) begin
          stat_q[cfd_pkg::NIB_POS] <= nib_d;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_lo_o <= 8'h00;
      res_hi_o <= 8'h00;
    end else if (ins_valid_i) begin
      res_lo_o <= lo_d;
      res_hi_o <= hi_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else if (reg_re_i) begin
      rdata_q <= (reg_addr_i == cfd_pkg::STAT_ADDR) ? stat_q : 8'h00;
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata_o = rdata_q;
  assign stat_o      = stat_q;

  // Operand decode, registered.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opd_addr_o <= 8'h00;
      opd_spec_o <= 1'b0;
    end else begin
      case (opd_mode_i)
        cfd_pkg::MODE_BANK: begin
          opd_addr_o <= {3'b000, stat_q[cfd_pkg::RS_LO +: 2], opd_i[2:0]};
          opd_spec_o <= 1'b0;
        end
        cfd_pkg::MODE_DIRECT: begin
          opd_addr_o <= opd_i;
          opd_spec_o <= (opd_i >= cfd_pkg::SPEC_BASE);
        end
        cfd_pkg::MODE_INDIRECT: begin
          opd_addr_o <= opd_i[0] ? ptr1_i : ptr0_i;
          opd_spec_o <= 1'b0;
        end
        default: begin
          opd_addr_o <= 8'h00;
          opd_spec_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rel_tgt_o <= 16'h0000;
      abs_tgt_o <= 16'h0000;
    end else begin
      rel_tgt_o <= pc_next_i + {{8{rel_i[7]}}, rel_i};
      abs_tgt_o <= {pc_next_i[15:11], abs11_i};
    end
  end

  // Pin synchroniser; level accepted when second and third stages agree.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_sync_q <= 3'b000;
      irq_lvl_q  <= 1'b0;
    end else begin
      irq_sync_q <= {irq_sync_q[1:0], irq_i};
      if (irq_sync_q[1] == irq_sync_q[2]) begin
        irq_lvl_q <= irq_sync_q[2];
      end
    end
  end

  // response sequencer bounded by the latency window.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_st_q <= cfd_pkg::IRQ_IDLE;
      lat_q    <= cfd_pkg::LAT_CNT_RST;
      push_q   <= 1'b0;
      pc_q     <= cfd_pkg::PC_RST;
    end else begin
      case (irq_st_q)
        cfd_pkg::IRQ_IDLE: begin
          lat_q  <= cfd_pkg::LAT_CNT_RST;
          push_q <= 1'b0;
          if (irq_lvl_q) begin
            irq_st_q <= cfd_pkg::IRQ_WAIT;
            lat_q    <= 8'h01;
          end
        end
        cfd_pkg::IRQ_WAIT: begin
          lat_q <= lat_q + 8'h01;
          if ((ins_done_i && (lat_q >= 8'(cfd_pkg::LAT_MIN_CYC -
                cfd_pkg::PUSH_CYC - 1))) ||
              (lat_q == 8'(cfd_pkg::LAT_MAX_CYC - cfd_pkg::PUSH_CYC - 1))) begin
            irq_st_q <= cfd_pkg::IRQ_PUSH;
            pc_q     <= pc_next_i;
          end
        end
        cfd_pkg::IRQ_PUSH: begin
          lat_q  <= lat_q + 8'h01;
          push_q <= ~push_q;
          if (push_q == 1'b1) begin
            irq_st_q <= cfd_pkg::IRQ_VEC;
          end
        end
        cfd_pkg::IRQ_VEC: begin
          irq_st_q <= irq_lvl_q ? cfd_pkg::IRQ_VEC : cfd_pkg::IRQ_IDLE;
          push_q   <= 1'b0;
        end
        default: irq_st_q <= cfd_pkg::IRQ_IDLE;
      endcase
    end
  end
  assign irq_push_o  = (irq_st_q == cfd_pkg::IRQ_PUSH);
  assign push_data_o = push_q ? pc_q[15:8] : pc_q[7:0];
  logic vec_seen_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vec_seen_q <= 1'b0;
    end else begin
      vec_seen_q <= (irq_st_q == cfd_pkg::IRQ_VEC);
    end
  end
  assign irq_vec_o = (irq_st_q == cfd_pkg::IRQ_VEC) && !vec_seen_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_prod_carry_clear: assert property (
    ins_valid_i && (ins_op_i == cfd_pkg::OP_PROD) |=> !stat_q[cfd_pkg::C_POS])
    else $error("product did not clear carry");
  a_bit_set_op_carry_set: assert property (
    ins_valid_i && (ins_op_i == cfd_pkg::OP_SETC) |=> stat_q[cfd_pkg::C_POS])
    else $error("carry set did not take");
  a_stat_byte_write: assert property (
    reg_we_i && (reg_addr_i == cfd_pkg::STAT_ADDR) && !ins_valid_i
    |=> stat_q == $past(reg_wdata_i))
    else $error("status byte write lost");
  a_irq_latency_max: assert property (
    (irq_st_q == cfd_pkg::IRQ_IDLE) && irq_lvl_q |-> ##[1:81] irq_vec_o)
    else $error("interrupt vector too late");
  a_irq_latency_min: assert property (
    (irq_st_q == cfd_pkg::IRQ_IDLE) && irq_lvl_q |=> !irq_vec_o [*8])
    else $error("interrupt vector too early");
  a_bank_reg_addr: assert property (
    opd_mode_i == cfd_pkg::MODE_BANK |=>
    opd_addr_o == {3'b000, $past(stat_q[4:3]), $past(opd_i[2:0])})
    else $error("bank register address wrong");
  a_direct_spec_split: assert property (
    opd_mode_i == cfd_pkg::MODE_DIRECT |=> opd_spec_o == $past(opd_i[7]))
    else $error("direct space split wrong");
  a_indirect_ptr_zero: assert property (
    (opd_mode_i == cfd_pkg::MODE_INDIRECT) && !opd_i[0]
    |=> (opd_addr_o == $past(ptr0_i)) && !opd_spec_o)
    else $error("pointer zero address wrong");
  a_indirect_ptr_one: assert property (
    (opd_mode_i == cfd_pkg::MODE_INDIRECT) && opd_i[0]
    |=> (opd_addr_o == $past(ptr1_i)) && !opd_spec_o)
    else $error("pointer one address wrong");
  a_rel_target: assert property (
    ##1 rel_tgt_o == $past(pc_next_i) + {{8{$past(rel_i[7])}}, $past(rel_i)})
    else $error("relative target wrong");
  a_abs_page_keep: assert property (
    ##1 abs_tgt_o[15:11] == $past(pc_next_i[15:11]))
    else $error("page bits changed");
  a_flags_hold: assert property (
    ins_valid_i && (ins_op_i == cfd_pkg::OP_LOGIC) && !reg_we_i && !bit_we_i
    |=> $stable(stat_q))
    else $error("flags changed by plain instruction");

  c_irq_serviced: cover property (irq_vec_o);
  c_stat_bit_write: cover property (bit_we_i && (bit_addr_i == 8'hd7));
  c_add_overflow: cover property (
    ins_valid_i && (ins_op_i == cfd_pkg::OP_ADD) && wrap_d);
endmodule : cfd_core
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the flag, status word, decode and interrupt core.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        rst_n;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, bit_addr;
  logic        reg_we, reg_re, bit_wdata, bit_we;
  logic        ins_valid, ins_bit;
  logic [4:0]  ins_op;
  logic [7:0]  ins_a, ins_b, res_lo, res_hi, stat;
  logic [1:0]  opd_mode;
  logic [7:0]  opd, ptr0, ptr1, opd_addr, rel, push_data;
  logic        opd_spec, irq, ins_done, irq_push, irq_vec;
  logic [15:0] pc_next, rel_tgt, abs_tgt;
  logic [10:0] abs11;
  int          bad_count, n_checks, cyc;

  cfd_core dut (
    .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
    .reg_rdata_o(reg_rdata), .bit_addr_i(bit_addr),
    .bit_wdata_i(bit_wdata), .bit_we_i(bit_we), .ins_valid_i(ins_valid),
    .ins_op_i(ins_op), .ins_a_i(ins_a), .ins_b_i(ins_b),
    .ins_bit_i(ins_bit), .res_lo_o(res_lo), .res_hi_o(res_hi),
    .stat_o(stat), .opd_mode_i(opd_mode), .opd_i(opd), .ptr0_i(ptr0),
    .ptr1_i(ptr1), .opd_addr_o(opd_addr), .opd_spec_o(opd_spec),
    .pc_next_i(pc_next), .rel_i(rel), .abs11_i(abs11),
    .rel_tgt_o(rel_tgt), .abs_tgt_o(abs_tgt), .irq_i(irq),
    .ins_done_i(ins_done), .irq_push_o(irq_push),
    .push_data_o(push_data), .irq_vec_o(irq_vec)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hung run short well beyond the expected length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re   <= 1'b0;
    #1;
    chk("rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rd

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clk);
    bit_we    <= 1'b1;
    bit_addr  <= a;
    bit_wdata <= v;
    @(posedge clk);
    bit_we    <= 1'b0;
  endtask : bw

  // Mask bit 0 compares the low result byte, bit 1 the high one.
  task automatic op(input logic [7:0] pre, input logic [4:0] o,
                    input logic [7:0] a, input logic [7:0] b,
                    input logic bv, input logic [7:0] lo,
                    input logic [7:0] hi, input logic [7:0] ps,
                    input logic [1:0] m);
    wr(cfd_pkg::STAT_ADDR, pre);
    @(posedge clk);
    ins_valid <= 1'b1;
    ins_op    <= o;
    ins_a     <= a;
    ins_b     <= b;
    ins_bit   <= bv;
    @(posedge clk);
    ins_valid <= 1'b0;
    #1;
    chk("stat", {8'h00, ps}, {8'h00, stat});
    if (m[0]) chk("res_lo", {8'h00, lo}, {8'h00, res_lo});
    if (m[1]) chk("res_hi", {8'h00, hi}, {8'h00, res_hi});
  endtask : op

  task automatic dec(input logic [1:0] md, input logic [7:0] o,
                     input logic [7:0] ea, input logic es);
    @(posedge clk);
    opd_mode <= md;
    opd      <= o;
    @(posedge clk);
    #1;
    chk("opd_addr", {8'h00, ea}, {8'h00, opd_addr});
    chk("opd_spec", {15'h0000, es}, {15'h0000, opd_spec});
  endtask : dec

  task automatic br(input logic [15:0] pc, input logic [7:0] r,
                    input logic [10:0] ab, input logic [15:0] er,
                    input logic [15:0] ea);
    @(posedge clk);
    pc_next <= pc;
    rel     <= r;
    abs11   <= ab;
    @(posedge clk);
    #1;
    chk("rel_tgt", er, rel_tgt);
    chk("abs_tgt", ea, abs_tgt);
  endtask : br

  // Latency counts from the pin rising, so it includes the input sync.
  task automatic intr(input logic done);
    int         n;
    int         np;
    logic [7:0] b0, b1;
    n  = 0;
    np = 0;
    b0 = 8'h00;
    b1 = 8'h00;
    @(posedge clk);
    ins_done <= done;
    irq      <= 1'b1;
    while (irq_vec !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
      if (irq_push === 1'b1) begin
        if (np == 0) b0 = push_data;
        else b1 = push_data;
        np++;
      end
    end
    chk("irq_lat_ok", 16'h0001, {15'h0000, n >= 38 && n <= 86});
    chk("push_cnt", 16'h0002, np[15:0]);
    chk("push_bytes", pc_next, {b1, b0});
    @(posedge clk);
    irq      <= 1'b0;
    ins_done <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : intr

  initial begin
    rst_n <= 1'b0;
    {reg_addr, reg_wdata, bit_addr, ins_a, ins_b, opd, rel} <= '0;
    {reg_we, reg_re, bit_wdata, bit_we, ins_valid, ins_bit} <= '0;
    {irq, ins_done, opd_mode, ins_op, abs11} <= '0;
    ptr0    <= 8'hc3;
    ptr1    <= 8'hfe;
    pc_next <= 16'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(cfd_pkg::STAT_ADDR, cfd_pkg::STAT_RST);
    op(8'h00, cfd_pkg::OP_ADD, 8'hff, 8'h01, 0, 8'h00, 0, 8'hc0, 1);
    op(8'h80, cfd_pkg::OP_ADCY, 8'h7f, 8'h00, 0, 8'h80, 0, 8'h44, 1);
    op(8'h00, cfd_pkg::OP_SBBR, 8'h00, 8'h01, 0, 8'hff, 0, 8'hc0, 1);
    op(8'h80, cfd_pkg::OP_SBBR, 8'h80, 8'h01, 0, 8'h7e, 0, 8'h44, 1);
    op(8'hc4, cfd_pkg::OP_PROD, 8'h10, 8'h10, 0, 8'h00, 8'h01, 8'h44, 3);
    op(8'h84, cfd_pkg::OP_QUOT, 8'h07, 8'h02, 0, 8'h03, 8'h01, 8'h00, 3);
    op(8'h00, cfd_pkg::OP_SETC, 8'h00, 8'h00, 0, 0, 0, 8'h80, 0);
    op(8'hc4, cfd_pkg::OP_CLRC, 8'h00, 8'h00, 0, 0, 0, 8'h44, 0);
    op(8'h00, cfd_pkg::OP_BCDA, 8'h9a, 8'h00, 0, 8'h00, 0, 8'h80, 1);
    op(8'h80, cfd_pkg::OP_RORC, 8'h01, 8'h00, 0, 8'h80, 0, 8'h80, 1);
    op(8'h00, cfd_pkg::OP_ROLC, 8'h80, 8'h00, 0, 8'h00, 0, 8'h80, 1);
    op(8'h80, cfd_pkg::OP_CPLC, 8'h00, 8'h00, 0, 0, 0, 8'h00, 0);
    op(8'h80, cfd_pkg::OP_ANLC, 8'h00, 8'h00, 0, 0, 0, 8'h00, 0);
    op(8'h00, cfd_pkg::OP_ORLC, 8'h00, 8'h00, 1, 0, 0, 8'h80, 0);
    op(8'h80, cfd_pkg::OP_ANLN, 8'h00, 8'h00, 1, 0, 0, 8'h00, 0);
    op(8'h00, cfd_pkg::OP_ORLN, 8'h00, 8'h00, 0, 0, 0, 8'h80, 0);
    op(8'h80, cfd_pkg::OP_MOVC, 8'h00, 8'h00, 0, 0, 0, 8'h00, 0);
    op(8'h00, cfd_pkg::OP_CMPJ, 8'h01, 8'h02, 0, 0, 0, 8'h80, 0);
    op(8'hc4, cfd_pkg::OP_NOP, 8'hff, 8'hff, 0, 0, 0, 8'hc4, 0);
    op(8'hc4, cfd_pkg::OP_LOGIC, 8'hff, 8'h01, 0, 0, 0, 8'hc4, 0);
    op(8'h18, cfd_pkg::OP_ADD, 8'h01, 8'h01, 0, 8'h02, 0, 8'h18, 1);
    wr(cfd_pkg::STAT_ADDR, 8'h00);
    bw(8'hd7, 1'b1);
    bw(8'hd2, 1'b1);
    rd(cfd_pkg::STAT_ADDR, 8'h84);
    bw(8'hd7, 1'b0);
    bw(8'hd6, 1'b1);
    rd(cfd_pkg::STAT_ADDR, 8'h44);
    wr(cfd_pkg::STAT_ADDR, 8'h5a);
    wr(8'h81, 8'hff);
    rd(cfd_pkg::STAT_ADDR, 8'h5a);
    rd(8'h81, 8'h00);
    wr(cfd_pkg::STAT_ADDR, 8'h10);
    dec(cfd_pkg::MODE_BANK, 8'h05, 8'h15, 1'b0);
    dec(cfd_pkg::MODE_BANK, 8'h07, 8'h17, 1'b0);
    dec(cfd_pkg::MODE_DIRECT, 8'h7f, 8'h7f, 1'b0);
    dec(cfd_pkg::MODE_DIRECT, 8'h80, 8'h80, 1'b1);
    dec(cfd_pkg::MODE_DIRECT, 8'hff, 8'hff, 1'b1);
    dec(cfd_pkg::MODE_INDIRECT, 8'h00, 8'hc3, 1'b0);
    dec(cfd_pkg::MODE_INDIRECT, 8'h01, 8'hfe, 1'b0);
    br(16'h1000, 8'h80, 11'h123, 16'h0f80, 16'h1123);
    br(16'h1000, 8'h7f, 11'h7ff, 16'h107f, 16'h17ff);
    br(16'h0ffe, 8'h05, 11'h000, 16'h1003, 16'h0800);
    br(16'h17fe, 8'hfe, 11'h7ff, 16'h17fc, 16'h17ff);
    @(posedge clk);
    pc_next <= 16'h1234;
    intr(1'b1);
    intr(1'b0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
